// ### verilog/wfx_map.vh
`ifndef WFX_MAP_VH
`define WFX_MAP_VH

// register offsets on the 4-bit address port
`define WFX_ADDR_W          4
`define WFX_OFS_FAULT_CTRL  4'h3
`define WFX_OFS_STATUS      4'h4
`define WFX_OFS_DT_BOTH     4'h6
`define WFX_OFS_DT_BOTH_BUF 4'h7
`define WFX_OFS_DT_LS       4'h8
`define WFX_OFS_DT_HS       4'h9
`define WFX_OFS_DT_LS_BUF   4'ha
`define WFX_OFS_DT_HS_BUF   4'hb
`define WFX_OFS_OVR_EN      4'hc

// fault control fields
`define WFX_FC_ACT_LSB      0
`define WFX_FC_ACT_MSB      1
`define WFX_FC_MODE_BIT     2
`define WFX_FC_DBD_BIT      4

// status fields
`define WFX_ST_LSV_BIT      0
`define WFX_ST_HSV_BIT      1
`define WFX_ST_FLAG_BIT     2

// fault action codes
`define WFX_ACT_NONE        2'h0
`define WFX_ACT_TRISTATE    2'h3

// restart modes
`define WFX_MODE_LATCHED    1'h0

// reset values and dead-time count end
`define WFX_RST_BYTE        8'h00
`define WFX_DT_ZERO         8'h00
`define WFX_DT_STEP         8'h01

`endif

// ### verilog/wfx_fault_dt.v
// Functional notes
// - debug break is a fault unless ignored
// - mode bit: 0 latched, 1 cycle-by-cycle
// - latched: wait flag clear, resume on update
// - cycle mode: resume on update once clear
// - action 11 tri-states dead-time pins, 00 off
// - masked event sets fault flag
// - fault flag cleared by writing one
// - buffer write sets valid, update transfers
// - timer lock blocks buffer transfers
// - both-sides write loads both dead times
// - both-sides buffer write loads both buffers
// - dead times are 8-bit clock counts
// - valid low buffer copied on update
// - valid high buffer copied on update
// - override enable writes blocked while flagged
// - override bits replace port output bits
// - counter reloads on edges, forces outputs off
// - fault action within two clocks
// - leaving fault restores dead-time pin directions
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "wfx_map.vh"

module wfx_fault_dt #(
  parameter N_CH = 4,
  parameter N_EV = 8,
  parameter N_PIN = 8
) (
  input  wire                   clk,
  input  wire                   rst_n,
  input  wire [`WFX_ADDR_W-1:0] addr,
  input  wire [7:0]             wr_data,
  input  wire                   wr_en,
  input  wire                   rd_en,
  output reg  [7:0]             rd_data,
  input  wire [N_EV-1:0]        fault_events,
  input  wire [N_EV-1:0]        fault_event_mask,
  input  wire                   dbg_break_req,
  input  wire                   update_strobe,
  input  wire                   timer_lock_update,
  input  wire [N_CH-1:0]        dti_chan_en,
  input  wire [N_CH-1:0]        wave_in,
  input  wire [N_PIN-1:0]       port_dir_in,
  input  wire [N_PIN-1:0]       port_out_in,
  output reg  [N_PIN-1:0]       port_dir_out,
  output reg  [N_PIN-1:0]       port_out,
  output reg                    fault_state
);

  // pins owned by enabled channels: low side 2k, high side 2k+1
  function [N_PIN-1:0] chan_pins;
    input [N_CH-1:0] en;
    integer k;
    begin
      chan_pins = {N_PIN{1'b0}};
      for (k = 0; k < N_CH; k = k + 1) begin
        chan_pins[2*k]   = en[k];
        chan_pins[2*k+1] = en[k];
      end
    end
  endfunction

  // software registers
  reg [1:0]       act_q;
  reg             mode_q;
  reg             ign_dbg_q;
  reg             flag_q;
  reg             lsv_q;
  reg             hsv_q;
  reg [7:0]       dt_ls_q;
  reg [7:0]       dt_hs_q;
  reg [7:0]       buf_ls_q;
  reg [7:0]       buf_hs_q;
  reg [N_PIN-1:0] ovr_en_q;
  reg [N_PIN-1:0] dir_save_q;

  // dead-time generator state
  reg [7:0]       cnt_q [0:N_CH-1];
  reg [N_CH-1:0]  wave_prev_q;
  reg [N_PIN-1:0] dti_pin;
  integer         j;

  // next values of flags, fault state and snapshot
  reg             flag_d;
  reg             fault_state_d;
  reg [N_PIN-1:0] dir_save_d;
  reg             lsv_d;
  reg             hsv_d;
  reg [7:0]       dt_ls_d;
  reg [7:0]       dt_hs_d;
  reg [7:0]       rd_d;

  // write decode
  wire wr_fc   = wr_en && (addr == `WFX_OFS_FAULT_CTRL);
  wire wr_st   = wr_en && (addr == `WFX_OFS_STATUS);
  wire wr_both = wr_en && (addr == `WFX_OFS_DT_BOTH);
  wire wr_bbuf = wr_en && (addr == `WFX_OFS_DT_BOTH_BUF);
  wire wr_ls   = wr_en && (addr == `WFX_OFS_DT_LS);
  wire wr_hs   = wr_en && (addr == `WFX_OFS_DT_HS);
  wire wr_lsb  = wr_en && (addr == `WFX_OFS_DT_LS_BUF);
  wire wr_hsb  = wr_en && (addr == `WFX_OFS_DT_HS_BUF);
  wire wr_ovr  = wr_en && (addr == `WFX_OFS_OVR_EN);

  // fault detection
  wire prot_on  = (act_q == `WFX_ACT_TRISTATE);
  wire ev_hit   = |(fault_events & fault_event_mask);
  wire brk_hit  = dbg_break_req && !ign_dbg_q;
  wire fault_in = prot_on && (ev_hit || brk_hit);
  wire flag_clr = wr_st && wr_data[`WFX_ST_FLAG_BIT];

  // recovery: condition gone, flag cleared in latched mode
  wire rec_ok = !fault_in &&
                ((mode_q != `WFX_MODE_LATCHED) || !flag_q);
  wire upd_ok = update_strobe && !timer_lock_update;

  wire [N_PIN-1:0] own_pins = chan_pins(dti_chan_en);

  // fault flag next value: set wins over the write-one clear
  always @* begin
    flag_d = flag_q;
    if (ev_hit || (prot_on && brk_hit))
      flag_d = 1'b1;
    else if (flag_clr)
      flag_d = 1'b0;
  end

  // fault state next value: enter on fault, leave at update or when the action is not tri-state
  always @* begin
    fault_state_d = fault_state;
    dir_save_d    = dir_save_q;
    if (fault_in) begin
      if (!fault_state)
        dir_save_d = port_dir_in;                            // snapshot on entry
      fault_state_d = 1'b1;
    end else if (!prot_on || (update_strobe && rec_ok)) begin
      fault_state_d = 1'b0;
    end
  end

  // fault control register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_q     <= `WFX_ACT_NONE;
      mode_q    <= `WFX_MODE_LATCHED;
      ign_dbg_q <= 1'b0;
    end else if (wr_fc) begin
      act_q     <= wr_data[`WFX_FC_ACT_MSB:`WFX_FC_ACT_LSB];
      mode_q    <= wr_data[`WFX_FC_MODE_BIT];
      ign_dbg_q <= wr_data[`WFX_FC_DBD_BIT];
    end
  end

  // fault flag, fault state and direction snapshot
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q      <= 1'b0;
      fault_state <= 1'b0;
      dir_save_q  <= {N_PIN{1'b0}};
    end else begin
      flag_q      <= flag_d;
      fault_state <= fault_state_d;
      dir_save_q  <= dir_save_d;
    end
  end

  // low side dead time: transfer first so a direct write wins
  always @* begin
    dt_ls_d = dt_ls_q;
    if (upd_ok && lsv_q)
      dt_ls_d = buf_ls_q;
    if (wr_both || wr_ls)
      dt_ls_d = wr_data;
  end

  // high side dead time: transfer first so a direct write wins
  always @* begin
    dt_hs_d = dt_hs_q;
    if (upd_ok && hsv_q)
      dt_hs_d = buf_hs_q;
    if (wr_both || wr_hs)
      dt_hs_d = wr_data;
  end

  // valid flags: buffer write sets, status write loads, transfer clears
  always @* begin
    lsv_d = lsv_q;
    hsv_d = hsv_q;
    if (wr_bbuf || wr_lsb)
      lsv_d = 1'b1;
    else if (wr_st)
      lsv_d = wr_data[`WFX_ST_LSV_BIT];
    else if (upd_ok)
      lsv_d = 1'b0;
    if (wr_bbuf || wr_hsb)
      hsv_d = 1'b1;
    else if (wr_st)
      hsv_d = wr_data[`WFX_ST_HSV_BIT];
    else if (upd_ok)
      hsv_d = 1'b0;
  end

  // dead-time values and valid flags
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dt_ls_q <= `WFX_RST_BYTE;
      dt_hs_q <= `WFX_RST_BYTE;
      lsv_q   <= 1'b0;
      hsv_q   <= 1'b0;
    end else begin
      dt_ls_q <= dt_ls_d;
      dt_hs_q <= dt_hs_d;
      lsv_q   <= lsv_d;
      hsv_q   <= hsv_d;
    end
  end

  // dead-time buffers, loaded singly or both at once
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_ls_q <= `WFX_RST_BYTE;
      buf_hs_q <= `WFX_RST_BYTE;
    end else begin
      if (wr_bbuf || wr_lsb)
        buf_ls_q <= wr_data;
      if (wr_bbuf || wr_hsb)
        buf_hs_q <= wr_data;
    end
  end

  // output override enable, frozen while flagged
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      ovr_en_q <= {N_PIN{1'b0}};
    else if (wr_ovr && !flag_q)
      ovr_en_q <= wr_data[N_PIN-1:0];
  end

  // dead-time counters: reload on edges, count down to zero
  integer i;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wave_prev_q <= {N_CH{1'b0}};
      for (i = 0; i < N_CH; i = i + 1)
        cnt_q[i] <= `WFX_DT_ZERO;
    end else begin
      wave_prev_q <= wave_in;
      for (i = 0; i < N_CH; i = i + 1) begin
        if (wave_in[i] && !wave_prev_q[i])
          cnt_q[i] <= dt_ls_q;
        else if (!wave_in[i] && wave_prev_q[i])
          cnt_q[i] <= dt_hs_q;
        else if (cnt_q[i] != `WFX_DT_ZERO)
          cnt_q[i] <= cnt_q[i] - `WFX_DT_STEP;
      end
    end
  end

  // side outputs: both off while counting
  always @* begin
    dti_pin = {N_PIN{1'b0}};
    for (j = 0; j < N_CH; j = j + 1) begin
      dti_pin[2*j]   = !wave_prev_q[j] && (cnt_q[j] == `WFX_DT_ZERO);
      dti_pin[2*j+1] = wave_prev_q[j] && (cnt_q[j] == `WFX_DT_ZERO);
    end
  end

  // port drive: owned-pin direction cleared in fault, outputs overridden
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port_dir_out <= {N_PIN{1'b0}};
      port_out     <= {N_PIN{1'b0}};
    end else begin
      if (fault_state)
        port_dir_out <= dir_save_q & ~own_pins;
      else
        port_dir_out <= port_dir_in;
      port_out <= (ovr_en_q & dti_pin) |
                  (~ovr_en_q & port_out_in);
    end
  end

  // read mux; reserved bits and unmapped offsets read zero
  always @* begin
    rd_d = `WFX_RST_BYTE;
    if (rd_en) begin
      case (addr)
        `WFX_OFS_FAULT_CTRL:  rd_d = {3'h0, ign_dbg_q, 1'h0, mode_q, act_q};
        `WFX_OFS_STATUS:      rd_d = {5'h00, flag_q, hsv_q, lsv_q};
        `WFX_OFS_DT_BOTH:     rd_d = dt_ls_q;
        `WFX_OFS_DT_BOTH_BUF: rd_d = buf_ls_q;
        `WFX_OFS_DT_LS:       rd_d = dt_ls_q;
        `WFX_OFS_DT_HS:       rd_d = dt_hs_q;
        `WFX_OFS_DT_LS_BUF:   rd_d = buf_ls_q;
        `WFX_OFS_DT_HS_BUF:   rd_d = buf_hs_q;
        `WFX_OFS_OVR_EN:      rd_d = ovr_en_q;
        default:              rd_d = `WFX_RST_BYTE;
      endcase
    end
  end

  // read data, valid the cycle after the strobe only
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      rd_data <= `WFX_RST_BYTE;
    else
      rd_data <= rd_d;
  end

endmodule

// ### tb/wfx_fault_dt_properties.sv
`timescale 1ns/1ps
module wfx_fault_dt_properties (
  input wire       clk,
  input wire       rst_n,
  input wire [3:0] addr,
  input wire [7:0] wr_data,
  input wire       wr_en,
  input wire [7:0] fault_events,
  input wire [7:0] fault_event_mask,
  input wire       dbg_break_req,
  input wire       update_strobe,
  input wire [3:0] dti_chan_en,
  input wire [7:0] port_dir_in,
  input wire [7:0] port_dir_out,
  input wire       fault_state
);
  reg  [7:0] ctl_q;
  wire       ev   = |(fault_events & fault_event_mask);
  wire       prot = ctl_q[1:0] == 2'h3;
  wire       ctlw = wr_en && addr == 4'h3;
  wire [7:0] own  = {{2{dti_chan_en[3]}}, {2{dti_chan_en[2]}},
                     {2{dti_chan_en[1]}}, {2{dti_chan_en[0]}}};
  // shadow of the fault control register
  always @(posedge clk or negedge rst_n)
    if (!rst_n) ctl_q <= 8'h00;
    else if (ctlw) ctl_q <= wr_data;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  event_entry_a: assert property (prot && !ctlw && ev |=> fault_state)
    else $error("no entry on event");
  break_entry_a: assert property (prot && !ctlw && dbg_break_req && !ctl_q[4] |=> fault_state)
    else $error("no entry on break");
  break_ignore_a: assert property (ctl_q[4] && !ev && !fault_state |=> !fault_state)
    else $error("entry without cause");
  action_off_a: assert property (!prot [*2] |-> !fault_state)
    else $error("fault while disabled");
  dir_clear_a: assert property (fault_state [*2] |-> (port_dir_out & own) == 8'h00)
    else $error("direction not cleared");
  dir_follow_a: assert property (!fault_state [*2] |-> port_dir_out == $past(port_dir_in))
    else $error("direction not restored");
  cycle_exit_a: assert property (fault_state && prot && ctl_q[2] && update_strobe && !ev
    && !(dbg_break_req && !ctl_q[4]) |=> !fault_state)
    else $error("no cycle recovery");
  update_only_a: assert property (fault_state && prot && !ctlw && !update_strobe |=> fault_state)
    else $error("exit without update");
endmodule

// ### tb/wfx_timer_model.sv
`timescale 1ns/1ps
module wfx_timer_model (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       slow,
  output reg        update_strobe,
  output reg        timer_lock_update,
  output reg  [3:0] wave_in
);
  reg [7:0] cnt_q;
  // free-running timer: update pulse, lock window, waveforms
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      update_strobe <= 1'b0;
      timer_lock_update <= 1'b0;
      wave_in <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 8'h01;
      update_strobe <= slow ? cnt_q == 8'hff : cnt_q[3:0] == 4'hf;
      timer_lock_update <= cnt_q[7:5] == 3'h5;
      wave_in <= cnt_q[5:2];
    end
  end
endmodule

// ### tb/wfx_fault_dt_bench.sv
`timescale 1ns/1ps
module wfx_fault_dt_bench;
  reg        clk, rst_n, wr_en, rd_en, dbg_break_req, slow, pend_q, lw, hw;
  reg  [3:0] addr, dti_chan_en;
  reg  [7:0] wr_data, fault_events, fault_event_mask, port_dir_in, port_out_in, exp_q;
  reg  [7:0] ov_q, po_q;
  wire       update_strobe, timer_lock_update, fault_state;
  wire [3:0] wave_in;
  wire [7:0] rd_data, port_dir_out, port_out;
  integer    fail_count, checks, seed, op, dv, k, n, m [0:15];
  wfx_fault_dt dut (.*);
  wfx_timer_model far (.*);
  task close_out;
    begin
      if (fail_count == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // register file model, read data checked every cycle
  always @(posedge clk) begin
    if (!rst_n) begin
      for (k = 0; k < 16; k = k + 1) m[k] = 0;
      pend_q = 1'b0;
      ov_q = 8'h00;
      po_q = 8'h00;
    end else begin
      exp_q = pend_q ? exp_q : 8'h00;
      checks = checks + 1;
      if (rd_data !== exp_q) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED rd_data expected %h seen %h", exp_q, rd_data);
      end
      checks = checks + 1;
      if ((port_out & ~ov_q) !== (po_q & ~ov_q)) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED port_out expected %h seen %h", po_q & ~ov_q, port_out & ~ov_q);
      end
      ov_q = m[12][7:0];
      po_q = port_out_in;
      pend_q = rd_en;
      exp_q = m[addr == 4'h6 ? 8 : addr == 4'h7 ? 10 : addr];
      lw = wr_en && (addr == 4'h7 || addr == 4'ha);
      hw = wr_en && (addr == 4'h7 || addr == 4'hb);
      if (update_strobe && !timer_lock_update) begin
        if (m[4][0]) m[8] = m[10];
        if (m[4][1]) m[9] = m[11];
        m[4] = m[4] & (4 + lw + 2 * hw);
      end
      if (wr_en && (addr == 4'h6 || addr == 4'h8)) m[8] = wr_data;
      if (wr_en && (addr == 4'h6 || addr == 4'h9)) m[9] = wr_data;
      if (lw) m[10] = wr_data;
      if (hw) m[11] = wr_data;
      m[4] = m[4] | lw | 2 * hw;
      if (wr_en && addr == 4'h4) m[4] = (m[4] & 4 | wr_data & 3) & ~(wr_data & 4);
      if (wr_en && addr == 4'hc && !m[4][2]) m[12] = wr_data;
      if (|(fault_events & fault_event_mask) || dbg_break_req && (m[3] & 8'h13) == 3)
        m[4] = m[4] | 4;
      if (wr_en && addr == 4'h3) m[3] = wr_data & 8'h17;
    end
  end
  // random register traffic, faults, breaks and port values
  initial begin
    {rst_n, wr_en, rd_en, dbg_break_req, slow, addr, dti_chan_en, wr_data} = 0;
    {fault_events, fault_event_mask, port_dir_in, port_out_in} = 0;
    fail_count = 0;
    checks = 0;
    seed = 4308;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    dti_chan_en <= $random(seed);
    for (n = 0; n < 4000; n = n + 1) begin
      @(posedge clk);
      op = $random(seed);
      dv = $random(seed);
      slow <= n > 2000;
      addr <= op[3:0];
      wr_en <= op[5:4] == 2'h1;
      rd_en <= op[5:4] == 2'h2;
      wr_data <= op[3:0] == 4'h3 ? dv[7:0] & 8'h17 : op[3:0] == 4'h4 ? dv[7:0] & 8'h07 : dv[7:0];
      fault_events <= op[9:6] == 4'h0 ? dv[15:8] : 8'h00;
      fault_event_mask <= dv[7:0];
      dbg_break_req <= op[12:10] == 3'h0;
      port_dir_in <= dv[23:16];
      port_out_in <= dv[31:24];
    end
    close_out;
  end
endmodule
bind wfx_fault_dt wfx_fault_dt_properties u_props (.*);
